// *** logic/transceiver_status_readout.sv ***
// Operation
// (R1) calibration-finished flag clears when calibration starts, sets when it ends
// (R2) lock-fail flag sets when sequencing ends without synthesizer lock
// (R3) status bit 5 is the raw instantaneous lock detector
// (R4) status bit 4 is lock filtered by the lock-criteria setting
// (R5) status bit 3 high while signal strength exceeds carrier threshold
// (R6) status bits 2..0 show lock, data clock and data pin levels
// (R7) reset-done register holds eight sub-block reset-complete flags
// (R8) top bit of signal strength always reads zero
// (R9) signal strength low seven bits, 1.5 dB per count
// (R10) 43h gives signed average offset, the decision level
// (R11) 44h gives signed instantaneous offset from nominal IF
// (R12) 45h gives calibration DAC high nibble, pump current low nibble
// (R13) 46h bits 7..5 give the silicon revision code
// (R14) 46h bits 4..0 give the applied oscillator band value
// (R15) 47h bit 7 frequency comparator, bit 6 oscillator current compare
// (R16) 47h bits 5..0 give the applied oscillator current value
// (R17) 48h gives mixer, in-phase and quadrature converter samples
// (R18) writes to the read-only bank change nothing
// (R19) pins and status inputs pass two flip-flops before use
`include "status_readout_regs.svh"

`default_nettype none

module transceiver_status_readout #(
   parameter logic [2:0] SILICON_REVISION = 3'h5, // arbitrary value
   parameter int LOCK_CNT_W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rd_data,
   // radio status, asynchronous
   input wire status_readout_pkg::radio_status_s radio_in,
   // configuration, same clock
   input wire logic [1:0] lock_criteria,
   input wire logic [6:0] carrier_threshold,
   // interrupt
   output logic irq
);

   // lock samples needed for a given criteria setting
   function automatic logic [LOCK_CNT_W-1:0] lock_need(input logic [1:0] crit);
      logic [7:0] n;
      n = `LOCK_CNT_0;
      if (crit == 2'h1)
         n = `LOCK_CNT_1;
      else if (crit == 2'h2)
         n = `LOCK_CNT_2;
      else if (crit == 2'h3)
         n = `LOCK_CNT_3;
      return LOCK_CNT_W'(n);
   endfunction : lock_need

   status_readout_pkg::reg_req_s req;
   assign req.addr = addr;
   assign req.wdata = wr_data;
   assign req.wr = wr_en;
   assign req.rd = rd_en;

   // two-stage synchroniser on every radio input
   status_readout_pkg::radio_status_s meta_q;
   status_readout_pkg::radio_status_s sync_q;

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= radio_in; // see (R19)
         sync_q <= meta_q; // see (R19)
      end
   end

   // delayed copies for edge detection, of the sync_q busy bits and of the filtered lock and carrier flags
   logic cal_busy_q;
   logic seq_busy_q;
   logic lock_filt_prev_q;
   logic carrier_prev_q;

   wire cal_start = sync_q.cal_busy && !cal_busy_q;
   wire cal_end = !sync_q.cal_busy && cal_busy_q;
   wire seq_start = sync_q.seq_busy && !seq_busy_q;
   wire seq_end = !sync_q.seq_busy && seq_busy_q;

   // calibration-finished flag
   logic cal_done_q;
   logic cal_done_d;
   assign cal_done_d = cal_start ? 1'b0 : (cal_end ? 1'b1 : cal_done_q); // see (R1)

   // lock filter: hysteresis counter on the raw detector
   logic [LOCK_CNT_W-1:0] lock_cnt_q;
   logic [LOCK_CNT_W-1:0] lock_cnt_d;
   logic lock_filt_q;
   logic lock_filt_d;
   wire [LOCK_CNT_W-1:0] lock_target = lock_need(lock_criteria);
   wire lock_agree = (sync_q.lock_now == lock_filt_q);
   wire lock_reached = (lock_cnt_q + LOCK_CNT_W'(1)) >= lock_target;

   // unlock drops at once, lock needs a run of good samples
   assign lock_cnt_d = (lock_agree || !sync_q.lock_now) ? '0 :
                       (lock_reached ? '0 : lock_cnt_q + LOCK_CNT_W'(1)); // see (R4)
   assign lock_filt_d = !sync_q.lock_now ? 1'b0 :
                        (lock_filt_q || lock_reached); // see (R4)

   // sequencer lock failure
   logic seq_fail_q;
   logic seq_fail_d;
   // fail is judged on the filtered lock at the end of sequencing
   assign seq_fail_d = seq_start ? 1'b0 :
                       ((seq_end && !lock_filt_q) ? 1'b1 : seq_fail_q); // see (R2)

   // carrier sense
   logic carrier_q;
   wire carrier_d = sync_q.signal_strength > carrier_threshold; // see (R5)

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cal_busy_q <= 1'b0;
         seq_busy_q <= 1'b0;
         cal_done_q <= `RST_CAL_DONE;
         seq_fail_q <= 1'b0;
         lock_cnt_q <= '0;
         lock_filt_q <= 1'b0;
         lock_filt_prev_q <= 1'b0;
         carrier_q <= 1'b0;
         carrier_prev_q <= 1'b0;
      end
      else
      begin
         cal_busy_q <= sync_q.cal_busy;
         seq_busy_q <= sync_q.seq_busy;
         cal_done_q <= cal_done_d;
         seq_fail_q <= seq_fail_d;
         lock_cnt_q <= lock_cnt_d;
         lock_filt_q <= lock_filt_d;
         lock_filt_prev_q <= lock_filt_q;
         carrier_q <= carrier_d;
         carrier_prev_q <= carrier_q;
      end
   end

   // register images
   wire [7:0] main_status = {
      cal_done_q, // see (R1)
      seq_fail_q, // see (R2)
      sync_q.lock_now, // see (R3)
      lock_filt_q, // see (R4)
      carrier_q, // see (R5)
      sync_q.lock_pin, // see (R6)
      sync_q.data_clock_pin,
      sync_q.data_inout_pin
   };
   wire [7:0] block_reset_done = sync_q.reset_done; // see (R7)
   wire [7:0] signal_strength = {1'b0, sync_q.signal_strength}; // see (R8) see (R9)
   wire [7:0] freq_offset_average = sync_q.average_frequency_offset; // see (R10)
   wire [7:0] freq_offset_instant = sync_q.instant_frequency_offset; // see (R11)
   wire [7:0] synth_cal_readout = {sync_q.cal_dac_value,
                                   sync_q.pump_current_value}; // see (R12)
   wire [7:0] revision_and_band = {SILICON_REVISION, // see (R13)
                                   sync_q.oscillator_band_value}; // see (R14)
   wire [7:0] oscillator_current_readout = {sync_q.freq_compare,
                                            sync_q.oscillator_current_compare, // see (R15)
                                            sync_q.oscillator_current_value}; // see (R16)
   wire [7:0] adc_sample_readout = {sync_q.adc_mixer, sync_q.adc_in_phase,
                                    sync_q.adc_quadrature}; // see (R17)

   // events: sticky status, cleared by reading, set wins over clear
   logic [`EV_WIDTH-1:0] ev_status_q;
   logic [`EV_WIDTH-1:0] ev_status_d;
   logic [`EV_WIDTH-1:0] ev_mask_q;
   logic [`EV_WIDTH-1:0] ev_mask_d;
   logic [`EV_WIDTH-1:0] ev_set;

   always_comb
   begin
      ev_set = '0;
      ev_set[`EV_CAL_DONE] = cal_end;
      ev_set[`EV_SEQ_FAIL] = seq_end && !lock_filt_q;
      ev_set[`EV_LOCK_LOST] = lock_filt_prev_q && !lock_filt_q;
      ev_set[`EV_CARRIER] = carrier_q && !carrier_prev_q;
   end

   wire rd_ev_status = req.rd && (req.addr == `OFS_EVENT_STATUS);
   wire wr_ev_mask = req.wr && (req.addr == `OFS_EVENT_MASK);

   assign ev_status_d = (rd_ev_status ? '0 : ev_status_q) | ev_set;
   // only the mask accepts writes, the status bank ignores them
   assign ev_mask_d = wr_ev_mask ? req.wdata[`EV_WIDTH-1:0] : ev_mask_q; // see (R18)

   // read decode
   logic [7:0] rd_mux;
   always_comb
   begin
      if (req.addr == `OFS_MAIN_STATUS)
         rd_mux = main_status;
      else if (req.addr == `OFS_BLOCK_RESET_DONE)
         rd_mux = block_reset_done;
      else if (req.addr == `OFS_SIGNAL_STRENGTH)
         rd_mux = signal_strength;
      else if (req.addr == `OFS_FREQ_OFFSET_AVERAGE)
         rd_mux = freq_offset_average;
      else if (req.addr == `OFS_FREQ_OFFSET_INSTANT)
         rd_mux = freq_offset_instant;
      else if (req.addr == `OFS_SYNTH_CAL_READOUT)
         rd_mux = synth_cal_readout;
      else if (req.addr == `OFS_REVISION_AND_BAND)
         rd_mux = revision_and_band;
      else if (req.addr == `OFS_OSC_CURRENT_READOUT)
         rd_mux = oscillator_current_readout;
      else if (req.addr == `OFS_ADC_SAMPLE_READOUT)
         rd_mux = adc_sample_readout;
      else if (req.addr == `OFS_EVENT_STATUS)
         rd_mux = {{(8-`EV_WIDTH){1'b0}}, ev_status_q};
      else if (req.addr == `OFS_EVENT_MASK)
         rd_mux = {{(8-`EV_WIDTH){1'b0}}, ev_mask_q};
      else
         rd_mux = 8'h00;
   end

   wire [7:0] rd_data_d = req.rd ? rd_mux : 8'h00;
   wire irq_d = |(ev_status_d & ev_mask_d);

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         ev_status_q <= '0;
         ev_mask_q <= `RST_EVENT_MASK;
         rd_data <= 8'h00;
         irq <= 1'b0;
      end
      else
      begin
         ev_status_q <= ev_status_d;
         ev_mask_q <= ev_mask_d;
         rd_data <= rd_data_d;
         irq <= irq_d;
      end
   end

endmodule : transceiver_status_readout

`default_nettype wire

// *** logic/status_readout_regs.svh ***
`ifndef STATUS_READOUT_REGS_SVH
`define STATUS_READOUT_REGS_SVH

// register offsets
`define OFS_MAIN_STATUS 8'h40
`define OFS_BLOCK_RESET_DONE 8'h41
`define OFS_SIGNAL_STRENGTH 8'h42
`define OFS_FREQ_OFFSET_AVERAGE 8'h43
`define OFS_FREQ_OFFSET_INSTANT 8'h44
`define OFS_SYNTH_CAL_READOUT 8'h45
`define OFS_REVISION_AND_BAND 8'h46
`define OFS_OSC_CURRENT_READOUT 8'h47
`define OFS_ADC_SAMPLE_READOUT 8'h48
`define OFS_EVENT_STATUS 8'h4C
`define OFS_EVENT_MASK 8'h4D

// main_status field positions
`define MS_CAL_DONE 7
`define MS_SEQ_FAIL 6
`define MS_LOCK_NOW 5
`define MS_LOCK_FILT 4
`define MS_CARRIER 3
`define MS_LOCK_PIN 2
`define MS_DATA_CLOCK_PIN_PIN 1
`define MS_DIO_PIN 0

// event bits
`define EV_CAL_DONE 0
`define EV_SEQ_FAIL 1
`define EV_LOCK_LOST 2
`define EV_CARRIER 3
`define EV_WIDTH 4

// reset values
`define RST_CAL_DONE 1'b0
`define RST_EVENT_MASK 4'h0

// consecutive lock samples needed per lock-criteria setting
`define LOCK_CNT_0 8'h01
`define LOCK_CNT_1 8'h08
`define LOCK_CNT_2 8'h20
`define LOCK_CNT_3 8'h80

`endif

// *** logic/status_readout_pkg.sv ***
`default_nettype none

package status_readout_pkg;

   // live inputs from the radio, all outside the register clock domain
   typedef struct packed {
      logic cal_busy;
      logic seq_busy;
      logic lock_now;
      logic lock_pin;
      logic data_clock_pin;
      logic data_inout_pin;
      logic [7:0] reset_done;
      logic [6:0] signal_strength;
      logic [7:0] average_frequency_offset;
      logic [7:0] instant_frequency_offset;
      logic [3:0] cal_dac_value;
      logic [3:0] pump_current_value;
      logic [4:0] oscillator_band_value;
      logic freq_compare;
      logic oscillator_current_compare;
      logic [5:0] oscillator_current_value;
      logic [1:0] adc_mixer;
      logic [2:0] adc_in_phase;
      logic [2:0] adc_quadrature;
   } radio_status_s;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

endpackage : status_readout_pkg

`default_nettype wire

// *** verif/transceiver_status_readout_checker.sv ***
`default_nettype none
module transceiver_status_readout_checker #(
   parameter logic [2:0] SILICON_REVISION = 3'h5,
   parameter int LOCK_CNT_W = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] rd_data,
   // radio, config, interrupt
   input wire status_readout_pkg::radio_status_s radio_in,
   input wire logic [1:0] lock_criteria,
   input wire logic [6:0] carrier_threshold,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   status_readout_pkg::radio_status_s seen_q;
   logic [6:0] thr_q;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   always_ff @(posedge clk)
   begin
      seen_q <= radio_in;
      thr_q <= carrier_threshold;
   end
   // inputs held long enough to cross the synchronisers
   sequence rd_at(logic [7:0] a);
      ($stable(radio_in) && $stable(carrier_threshold))[*5] ##0 rd_en && addr == a;
   endsequence
   a_write_silent:
      assert property (wr_en |=> rd_data == 8'h00)
      else $error("write gave read data");
   a_strength_msb:
      assert property (rd_en && addr == 8'h42 |=> !rd_data[7])
      else $error("strength top bit set");
   a_revision_code:
      assert property (rd_en && addr == 8'h46 |=> rd_data[7:5] == SILICON_REVISION)
      else $error("revision field wrong");
   a_done_flags:
      assert property (rd_at(8'h41) |=> rd_data == seen_q.reset_done)
      else $error("reset done flags wrong");
   a_pin_levels:
      assert property (rd_at(8'h40) |=> rd_data[2:0] ==
         {seen_q.lock_pin, seen_q.data_clock_pin, seen_q.data_inout_pin})
      else $error("pin levels wrong");
   a_lock_raw:
      assert property (rd_at(8'h40) |=> rd_data[5] == seen_q.lock_now)
      else $error("raw lock bit wrong");
   a_lock_drop:
      assert property (rd_at(8'h40) ##0 !radio_in.lock_now |=> !rd_data[4])
      else $error("filtered lock set without lock");
   a_carrier_sense:
      assert property (rd_at(8'h40) |=> rd_data[3] == (seen_q.signal_strength > thr_q))
      else $error("carrier bit wrong");
   a_cal_flag:
      assert property (rd_at(8'h40) ##0 radio_in.cal_busy |=> !rd_data[7])
      else $error("cal flag set during calibration");
   a_band_value:
      assert property (rd_at(8'h46) |=> rd_data[4:0] == seen_q.oscillator_band_value)
      else $error("band value wrong");
   a_adc_sample:
      assert property (rd_at(8'h48) |=> rd_data ==
         {seen_q.adc_mixer, seen_q.adc_in_phase, seen_q.adc_quadrature})
      else $error("adc sample wrong");
endmodule : transceiver_status_readout_checker

bind transceiver_status_readout transceiver_status_readout_checker #(
   .SILICON_REVISION(SILICON_REVISION),
   .LOCK_CNT_W(LOCK_CNT_W)
) chk_i (
   .clk(clk), .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
   .rd_data(rd_data), .radio_in(radio_in), .lock_criteria(lock_criteria),
   .carrier_threshold(carrier_threshold), .irq(irq)
);
`default_nettype wire

// *** verif/transceiver_status_readout_tb.sv ***
`default_nettype none
module transceiver_status_readout_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [2:0] REV = 3'h2; // arbitrary value
   logic clk;
   logic nrst;
   logic [7:0] addr;
   logic [7:0] wr_data;
   logic wr_en;
   logic rd_en;
   logic [7:0] rd_data;
   status_readout_pkg::radio_status_s radio_in;
   logic [1:0] lock_criteria;
   logic [6:0] carrier_threshold;
   logic irq;
   int num_errors = 0;
   int compares = 0;
   int cycles = 0;
   transceiver_status_readout #(.SILICON_REVISION(REV), .LOCK_CNT_W(8)) dut (
      .clk(clk), .nrst(nrst), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
      .rd_data(rd_data), .radio_in(radio_in), .lock_criteria(lock_criteria),
      .carrier_threshold(carrier_threshold), .irq(irq));
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      d = rd_data;
   endtask : rd
   task automatic settle;
      repeat (6) @(posedge clk);
   endtask : settle
   task automatic summarize;
      $display("compares %0d errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : summarize
   task automatic t_status;
      logic [7:0] d;
      rd(8'h40, d);
      chk(d, 8'h00);
      chk({7'h00, irq}, 8'h00);
      settle();
      radio_in.lock_now <= 1'b1;
      radio_in.lock_pin <= 1'b1;
      radio_in.data_inout_pin <= 1'b1;
      radio_in.signal_strength <= 7'h40;
      carrier_threshold <= 7'h3F;
      settle();
      rd(8'h40, d);
      chk(d, 8'h3D);
      settle();
      carrier_threshold <= 7'h40;
      radio_in.lock_pin <= 1'b0;
      radio_in.data_clock_pin <= 1'b1;
      radio_in.data_inout_pin <= 1'b0;
      settle();
      rd(8'h40, d);
      chk(d, 8'h32);
      $display("status done");
   endtask : t_status
   task automatic t_readout;
      logic [7:0] d;
      logic [7:0] exp [9];
      settle();
      radio_in.reset_done <= 8'hA5;
      radio_in.signal_strength <= 7'h7F;
      radio_in.average_frequency_offset <= 8'h81;
      radio_in.instant_frequency_offset <= 8'h7E;
      radio_in.cal_dac_value <= 4'hC;
      radio_in.pump_current_value <= 4'h3;
      radio_in.oscillator_band_value <= 5'h15;
      radio_in.freq_compare <= 1'b1;
      radio_in.oscillator_current_compare <= 1'b1;
      radio_in.oscillator_current_value <= 6'h15;
      radio_in.adc_mixer <= 2'h2;
      radio_in.adc_in_phase <= 3'h5;
      radio_in.adc_quadrature <= 3'h3;
      settle();
      exp = '{8'h32, 8'hA5, 8'h7F, 8'h81, 8'h7E, 8'hC3, {REV, 5'h15}, 8'hD5, 8'hAB};
      for (int k = 0; k < 2; k++)
      begin
         for (int i = 1; i < 9; i++)
         begin
            rd(8'(8'h40 + i), d);
            chk(d, exp[i]);
            wr(8'(8'h40 + i), 8'h00);
         end
      end
      rd(8'h50, d);
      chk(d, 8'h00);
      $display("readout done");
   endtask : t_readout
   task automatic t_lock_filter;
      logic [7:0] d;
      int need [4] = '{1, 8, 32, 128};
      // filtered bit must still be low after need samples, high one edge later
      for (int c = 0; c < 4; c++)
      begin
         for (int n = 0; n < 2; n++)
         begin
            settle();
            lock_criteria <= 2'(c);
            radio_in.lock_now <= 1'b0;
            settle();
            radio_in.lock_now <= 1'b1;
            repeat (need[c] + n) @(posedge clk);
            rd(8'h40, d);
            chk({6'h00, d[5:4]}, {6'h00, 1'b1, 1'(n)});
         end
      end
      $display("lock filter done");
   endtask : t_lock_filter
   task automatic seq_pulse;
      radio_in.seq_busy <= 1'b1;
      settle();
      radio_in.seq_busy <= 1'b0;
      settle();
   endtask : seq_pulse
   task automatic t_seq_fail;
      logic [7:0] d;
      settle();
      seq_pulse();
      rd(8'h40, d);
      chk({7'h00, d[6]}, 8'h00);
      settle();
      radio_in.lock_now <= 1'b0;
      settle();
      seq_pulse();
      rd(8'h40, d);
      chk({7'h00, d[6]}, 8'h01);
      settle();
      radio_in.seq_busy <= 1'b1;
      settle();
      rd(8'h40, d);
      chk({7'h00, d[6]}, 8'h00);
      $display("seq fail done");
   endtask : t_seq_fail
   task automatic t_cal_irq;
      logic [7:0] d;
      rd(8'h4C, d);
      settle();
      radio_in.cal_busy <= 1'b1;
      settle();
      rd(8'h40, d);
      chk({7'h00, d[7]}, 8'h00);
      settle();
      radio_in.cal_busy <= 1'b0;
      settle();
      rd(8'h40, d);
      chk({7'h00, d[7]}, 8'h01);
      chk({7'h00, irq}, 8'h00);
      wr(8'h4D, 8'h01);
      @(posedge clk);
      #1;
      chk({7'h00, irq}, 8'h01);
      rd(8'h4C, d);
      chk(d & 8'h01, 8'h01);
      chk({7'h00, irq}, 8'h00);
      rd(8'h4C, d);
      chk(d & 8'h01, 8'h00);
      // a second calibration must clear the finished flag again
      settle();
      radio_in.cal_busy <= 1'b1;
      settle();
      rd(8'h40, d);
      chk({7'h00, d[7]}, 8'h00);
      $display("cal irq done");
   endtask : t_cal_irq
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         num_errors++;
         summarize();
      end
   end
   initial
   begin
      nrst = 1'b0;
      addr = 8'h00;
      wr_data = 8'h00;
      wr_en = 1'b0;
      rd_en = 1'b0;
      radio_in = '0;
      lock_criteria = 2'h0;
      carrier_threshold = 7'h7F;
      repeat (12) @(posedge clk);
      nrst <= 1'b1;
      t_status();
      t_readout();
      t_lock_filter();
      t_seq_fail();
      t_cal_irq();
      summarize();
   end
endmodule : transceiver_status_readout_tb
`default_nettype wire
